// ### src/opvsr_device.sv
// Device end: self-timed one-wire receiver, mode select, enables, phasing.
// Assumes the link interface resolves the wire; pins are asynchronous.
//
// Summary of operation
// RL1 - Written voltages survive until lockout reset only
// RL2 - Line high forces PWM at once
// RL3 - Power save only after 520 us low
// RL4 - Separate enables; soft start on rising enable
// RL5 - Both enables low means full shutdown
// RL6 - Select pin picks converter 1 low/high register
// RL7 - High-side turn-on offset by half period
// RL8 - Address byte then data byte; address compared
// RL9 - Data byte: ack request, select, five bits
// RL10 - Acknowledge only on error-free reception
// RL11 - Bit judged by timing ratio, any rate
// RL12 - Bytes shifted in MSB first
// RL13 - Host start hold before each byte
// RL14 - Host end-of-stream after each byte
// RL15 - Three 5-bit voltage registers
// RL16 - Select codes 00, 01, 10; 11 reserved
// RL17 - Analog variant: one register per converter
// RL18 - Receiver on with an enable, after 170 ms
// RL19 - One if high twice low, zero reverse
// RL20 - Ack needs request, address match, 16 bits
// RL21 - Ack pulse after valid delay, 520 us max
// RL22 - PWM held throughout a reception
// RL23 - Bad address or reserved code discarded
`timescale 1ns/1ps
module opvsr_device #(
  parameter logic [opvsr_pkg::CNT_W-1:0] STARTUP_CYC   = opvsr_pkg::STARTUP_CYC,
  parameter logic [opvsr_pkg::CNT_W-1:0] PSAVE_CYC     = opvsr_pkg::PSAVE_CYC,
  parameter logic [opvsr_pkg::CNT_W-1:0] ACK_PULSE_CYC = opvsr_pkg::ACK_PULSE_CYC,
  parameter bit                          FIXED_VARIANT = 1'b1
) (
  // Clock and reset (reset stands for supply lockout)
  input  wire logic       core_clk,
  input  wire logic       srst,
  // Link
  opvsr_link_if.dev       lk,
  // Pins
  input  wire logic       conv1_enable,
  input  wire logic       conv2_enable,
  input  wire logic       conv1_select_pin,
  // Converter control
  output logic [4:0]      conv1_voltage,
  output logic [4:0]      conv2_voltage,
  output logic            pwm_forced,
  output logic            conv1_run,
  output logic            conv2_run,
  output logic            conv1_soft_start,
  output logic            conv2_soft_start,
  output logic            shutdown,
  output logic            conv1_hs_on,
  output logic            conv2_hs_on,
  output logic            rx_ready
);

  typedef struct packed {
    opvsr_pkg::opvsr_dev_st_t    st;
    logic [3:0]                  s1;
    logic [3:0]                  s2;
    logic [3:0]                  s3;
    logic [3:0]                  stab;
    logic [opvsr_pkg::BIT_W-1:0] tlow;
    logic [opvsr_pkg::BIT_W-1:0] thigh;
    logic [4:0]                  nbits;
    logic [15:0]                 shreg;
    logic                        err;
    logic [opvsr_pkg::CNT_W-1:0] lowcnt;
    logic                        psave;
    logic [opvsr_pkg::CNT_W-1:0] upcnt;
    logic                        ready;
    logic [opvsr_pkg::CNT_W-1:0] tcnt;
    logic [4:0]                  c1l;
    logic [4:0]                  c1h;
    logic [4:0]                  c2;
    logic [4:0]                  v1;
    logic [4:0]                  v2;
    logic                        pwm;
    logic                        run1;
    logic                        run2;
    logic                        ss1;
    logic                        ss2;
    logic                        sdn;
    logic [7:0]                  ph;
    logic                        hs1;
    logic                        hs2;
    logic                        oe;
  } opvsr_dev_state_t;

  localparam logic [opvsr_pkg::BIT_W-1:0] BIT_MAX = 16'hFFFF;
  localparam logic [opvsr_pkg::CNT_W-1:0] CNT_ONE = 23'h000001;
  localparam logic [7:0]                  SW_LAST = opvsr_pkg::SW_PERIOD_CYC - 8'h01;

  opvsr_dev_state_t st_ff;
  opvsr_dev_state_t nxt_st;

  // Saturating bit timer increment
  function automatic logic [opvsr_pkg::BIT_W-1:0] sat_inc(
    input logic [opvsr_pkg::BIT_W-1:0] v);
    sat_inc = (v == BIT_MAX) ? v : v + 16'h0001;
  endfunction

  logic       fall;
  logic       rise;
  logic       en_any;
  logic       timeout;
  logic       bit_one;
  logic       bit_zero;
  logic [15:0] frame;
  logic       sel_ok;
  logic       frame_ok;

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    nxt_st = st_ff;
    // Three-stage synchroniser; a change counts when stages two and three agree
    nxt_st.s1   = {lk.line, conv1_select_pin, conv2_enable, conv1_enable};
    nxt_st.s2   = st_ff.s1;
    nxt_st.s3   = st_ff.s2;
    nxt_st.stab = (st_ff.s2 & st_ff.s3) | (st_ff.stab & (st_ff.s2 ^ st_ff.s3));

    fall   = st_ff.stab[opvsr_pkg::PIN_LINE] & ~nxt_st.stab[opvsr_pkg::PIN_LINE];
    rise   = ~st_ff.stab[opvsr_pkg::PIN_LINE] & nxt_st.stab[opvsr_pkg::PIN_LINE];
    en_any = nxt_st.stab[opvsr_pkg::PIN_EN1] | nxt_st.stab[opvsr_pkg::PIN_EN2];

    // Receiver comes alive only with an enable, after the startup time
    if (!en_any) begin
      nxt_st.upcnt = '0; // RL18
      nxt_st.ready = 1'b0;
    end else if (st_ff.upcnt != STARTUP_CYC) begin
      nxt_st.upcnt = st_ff.upcnt + CNT_ONE;
    end else begin
      nxt_st.ready = 1'b1; // RL18
    end

    // Low-time watchdog; own acknowledge pulse must not trip it
    timeout = 1'b0;
    if (nxt_st.stab[opvsr_pkg::PIN_LINE] || st_ff.st == opvsr_pkg::D_ACKWAIT ||
        st_ff.st == opvsr_pkg::D_ACK) begin
      nxt_st.lowcnt = '0;
    end else if (st_ff.lowcnt != PSAVE_CYC) begin
      nxt_st.lowcnt = st_ff.lowcnt + CNT_ONE;
    end else begin
      timeout = 1'b1; // RL3
    end
    if (nxt_st.stab[opvsr_pkg::PIN_LINE]) begin
      nxt_st.psave = 1'b0; // RL2
    end else if (timeout) begin
      nxt_st.psave = 1'b1; // RL3
    end

    // Ratio decision, independent of bit rate
    // High count closes on the falling edge, so its last cycle is added here
    bit_one  = {1'b0, sat_inc(st_ff.thigh)} >= {st_ff.tlow, 1'b0}; // RL19 RL11
    bit_zero = {1'b0, st_ff.tlow} >= {sat_inc(st_ff.thigh), 1'b0}; // RL19 RL11
    frame    = {st_ff.shreg[14:0], bit_one}; // RL12
    sel_ok   = (frame[opvsr_pkg::SEL_MSB:opvsr_pkg::SEL_LSB] == opvsr_pkg::SEL_C1_LOW) ||
               (frame[opvsr_pkg::SEL_MSB:opvsr_pkg::SEL_LSB] == opvsr_pkg::SEL_C2) ||
               (FIXED_VARIANT &&
                frame[opvsr_pkg::SEL_MSB:opvsr_pkg::SEL_LSB] == opvsr_pkg::SEL_C1_HIGH); // RL16 RL17
    frame_ok = ~st_ff.err & (bit_one | bit_zero) &
               (frame[15:opvsr_pkg::ADDR_LSB] == opvsr_pkg::DEV_ADDR) & sel_ok; // RL8 RL23

    nxt_st.oe = 1'b0;
    case (st_ff.st)
      opvsr_pkg::D_IDLE: begin
        if (fall) begin
          nxt_st.st    = opvsr_pkg::D_LOW;
          nxt_st.tlow  = '0;
          nxt_st.thigh = '0;
          nxt_st.nbits = '0;
          nxt_st.err   = 1'b0;
        end
      end
      opvsr_pkg::D_LOW: begin
        nxt_st.tlow = sat_inc(st_ff.tlow);
        if (rise) begin
          nxt_st.st = opvsr_pkg::D_HIGH;
        end
      end
      opvsr_pkg::D_HIGH: begin
        nxt_st.thigh = sat_inc(st_ff.thigh);
        if (fall) begin
          nxt_st.shreg = frame; // RL12
          nxt_st.err   = st_ff.err | ~(bit_one | bit_zero); // RL19
          nxt_st.nbits = st_ff.nbits + 5'h01;
          nxt_st.tlow  = '0;
          nxt_st.thigh = '0;
          if (nxt_st.nbits == opvsr_pkg::FRAME_BITS) begin
            nxt_st.st = opvsr_pkg::D_IDLE;
            if (frame_ok) begin // RL10 RL23
              case (frame[opvsr_pkg::SEL_MSB:opvsr_pkg::SEL_LSB]) // RL16
                opvsr_pkg::SEL_C1_LOW:  nxt_st.c1l = frame[opvsr_pkg::DATA_MSB:0]; // RL15
                opvsr_pkg::SEL_C1_HIGH: nxt_st.c1h = frame[opvsr_pkg::DATA_MSB:0]; // RL15
                opvsr_pkg::SEL_C2:      nxt_st.c2  = frame[opvsr_pkg::DATA_MSB:0]; // RL15
                default: ;
              endcase
              if (frame[opvsr_pkg::ACK_BIT]) begin // RL9 RL20
                nxt_st.st   = opvsr_pkg::D_ACKWAIT;
                nxt_st.tcnt = '0;
              end
            end
          end else if (nxt_st.nbits == opvsr_pkg::BYTE_BITS) begin
            nxt_st.st = opvsr_pkg::D_GAP; // RL8
          end else begin
            nxt_st.st = opvsr_pkg::D_LOW;
          end
        end
      end
      opvsr_pkg::D_GAP: begin
        // End-of-stream low and start high are not a bit
        if (fall) begin
          nxt_st.st = opvsr_pkg::D_LOW;
        end
      end
      opvsr_pkg::D_ACKWAIT: begin
        nxt_st.tcnt = st_ff.tcnt + CNT_ONE;
        if (nxt_st.tcnt == opvsr_pkg::ACK_VALID_CYC) begin
          nxt_st.st   = opvsr_pkg::D_ACK; // RL21
          nxt_st.tcnt = '0;
          nxt_st.oe   = 1'b1;
        end
      end
      opvsr_pkg::D_ACK: begin
        nxt_st.tcnt = st_ff.tcnt + CNT_ONE;
        nxt_st.oe   = 1'b1; // RL21
        if (nxt_st.tcnt == ACK_PULSE_CYC) begin
          nxt_st.st = opvsr_pkg::D_IDLE;
          nxt_st.oe = 1'b0;
        end
      end
      default: nxt_st.st = opvsr_pkg::D_IDLE;
    endcase

    // A long low aborts a partial frame; no receiver before ready
    if ((timeout && (st_ff.st == opvsr_pkg::D_LOW || st_ff.st == opvsr_pkg::D_GAP)) ||
        !nxt_st.ready) begin
      nxt_st.st = opvsr_pkg::D_IDLE; // RL18
      nxt_st.oe = 1'b0;
    end

    // Converter control
    nxt_st.v1 = (FIXED_VARIANT && nxt_st.stab[opvsr_pkg::PIN_SEL]) ? nxt_st.c1h
                                                                    : nxt_st.c1l; // RL6 RL17
    nxt_st.v2   = nxt_st.c2;
    nxt_st.pwm  = ~nxt_st.psave | (nxt_st.st != opvsr_pkg::D_IDLE); // RL2 RL22
    nxt_st.run1 = nxt_st.stab[opvsr_pkg::PIN_EN1]; // RL4
    nxt_st.run2 = nxt_st.stab[opvsr_pkg::PIN_EN2]; // RL4
    nxt_st.ss1  = nxt_st.stab[opvsr_pkg::PIN_EN1] & ~st_ff.stab[opvsr_pkg::PIN_EN1]; // RL4
    nxt_st.ss2  = nxt_st.stab[opvsr_pkg::PIN_EN2] & ~st_ff.stab[opvsr_pkg::PIN_EN2]; // RL4
    nxt_st.sdn  = ~en_any; // RL5

    // Phase pulses only in PWM; in power save switching is load driven
    nxt_st.hs1 = 1'b0;
    nxt_st.hs2 = 1'b0;
    if (nxt_st.sdn || !nxt_st.pwm) begin
      nxt_st.ph = '0; // RL5
    end else begin
      nxt_st.ph  = (st_ff.ph == SW_LAST) ? 8'h00 : st_ff.ph + 8'h01;
      nxt_st.hs1 = nxt_st.run1 && st_ff.ph == 8'h00; // RL7
      nxt_st.hs2 = nxt_st.run2 && st_ff.ph == opvsr_pkg::SW_HALF_CYC; // RL7
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; reset stands for supply lockout
  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_ff      <= '0;
      st_ff.st   <= opvsr_pkg::D_IDLE;
      st_ff.c1l  <= opvsr_pkg::C1_LOW_DEF; // RL1
      st_ff.c1h  <= opvsr_pkg::C1_HIGH_DEF; // RL1
      st_ff.c2   <= opvsr_pkg::C2_DEF; // RL1
      st_ff.v1   <= opvsr_pkg::C1_LOW_DEF;
      st_ff.v2   <= opvsr_pkg::C2_DEF;
      st_ff.pwm  <= 1'b1;
      st_ff.sdn  <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign lk.dev_o         = 1'b0;
  assign lk.dev_oe        = st_ff.oe;
  assign conv1_voltage    = st_ff.v1;
  assign conv2_voltage    = st_ff.v2;
  assign pwm_forced       = st_ff.pwm;
  assign conv1_run        = st_ff.run1;
  assign conv2_run        = st_ff.run2;
  assign conv1_soft_start = st_ff.ss1;
  assign conv2_soft_start = st_ff.ss2;
  assign shutdown         = st_ff.sdn;
  assign conv1_hs_on      = st_ff.hs1;
  assign conv2_hs_on      = st_ff.hs2;
  assign rx_ready         = st_ff.ready;

endmodule

// ### src/opvsr_pkg.sv
// Shared constants and types for the one-pin voltage set link.
// Assumes a single 25 MHz core clock on both ends of the link.
package opvsr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths and timing
  localparam int unsigned CNT_W          = 23;
  localparam int unsigned BIT_W          = 16;
  localparam int unsigned CLK_PERIOD_NS  = 40;
  localparam int unsigned PSAVE_DELAY_US = 520;
  localparam int unsigned STARTUP_MS     = 170;
  localparam int unsigned ACK_PULSE_US   = 520;
  localparam int unsigned ACK_VALID_NS   = 2000;
  // Longest times round down, least times round up
  localparam logic [CNT_W-1:0] PSAVE_CYC     = CNT_W'(PSAVE_DELAY_US * 1000 / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] STARTUP_CYC   = CNT_W'(STARTUP_MS * 1000000 / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] ACK_PULSE_CYC = CNT_W'(ACK_PULSE_US * 1000 / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] ACK_VALID_CYC =
    CNT_W'((ACK_VALID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Host side bit timing
  localparam int unsigned HOST_BIT_NS   = 10000;
  localparam int unsigned HOST_START_NS = 10000;
  localparam int unsigned HOST_EOS_NS   = 10000;
  localparam logic [CNT_W-1:0] HOST_BIT_CYC   = CNT_W'(HOST_BIT_NS / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] HOST_START_CYC =
    CNT_W'((HOST_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] HOST_EOS_CYC   =
    CNT_W'((HOST_EOS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] ACK_MARGIN_CYC = 23'h000008;
  localparam logic [CNT_W-1:0] ACK_SAMPLE_CYC = 23'h000006;

  ////////////////////////////////////////////////////////////////////////////
  // Frame layout
  localparam logic [7:0] DEV_ADDR     = 8'hA5;  // Arbitrary value
  localparam logic [4:0] BYTE_BITS    = 5'h08;
  localparam logic [4:0] FRAME_BITS   = 5'h10;
  localparam int unsigned ACK_BIT     = 7;
  localparam int unsigned SEL_MSB     = 6;
  localparam int unsigned SEL_LSB     = 5;
  localparam int unsigned DATA_MSB    = 4;
  localparam int unsigned ADDR_LSB    = 8;
  localparam logic [1:0] SEL_C1_LOW   = 2'h0;
  localparam logic [1:0] SEL_C1_HIGH  = 2'h1;
  localparam logic [1:0] SEL_C2       = 2'h2;

  // Register defaults after lockout
  localparam logic [4:0] C1_LOW_DEF   = 5'h00;
  localparam logic [4:0] C1_HIGH_DEF  = 5'h0C;
  localparam logic [4:0] C2_DEF       = 5'h0C;

  // Synchronised pin positions
  localparam int unsigned PIN_EN1  = 0;
  localparam int unsigned PIN_EN2  = 1;
  localparam int unsigned PIN_SEL  = 2;
  localparam int unsigned PIN_LINE = 3;

  // Switching period in core cycles, high-side turn-on offset by half
  localparam logic [7:0] SW_PERIOD_CYC = 8'h0B;
  localparam logic [7:0] SW_HALF_CYC   = 8'h05;

  ////////////////////////////////////////////////////////////////////////////
  // States
  typedef enum logic [2:0] {D_IDLE, D_LOW, D_HIGH, D_GAP, D_ACKWAIT, D_ACK} opvsr_dev_st_t;
  typedef enum logic [2:0] {H_IDLE, H_START, H_LOW, H_HIGH, H_EOS, H_ACKREL, H_ACKWT}
    opvsr_host_st_t;

endpackage

// ### src/opvsr_link_if.sv
// Single open-drain mode/data wire shared by host and device.
// Assumes an external pull-up: the wire is high unless an end pulls it low.
`timescale 1ns/1ps
interface opvsr_link_if;
  logic host_o;
  logic host_oe;
  logic dev_o;
  logic dev_oe;
  logic line;

  // Wired-AND with pull-up
  assign line = (host_oe ? host_o : 1'b1) & (dev_oe ? dev_o : 1'b1);

  modport dev  (input line, output dev_o, output dev_oe);
  modport host (input line, output host_o, output host_oe);
endinterface

// ### src/opvsr_host.sv
// Host end: sends address and data byte, optionally reads acknowledge.
// Assumes the link interface resolves the wire; host output is open drain.
`timescale 1ns/1ps
module opvsr_host #(
  parameter logic [opvsr_pkg::CNT_W-1:0] ACK_PULSE_CYC = opvsr_pkg::ACK_PULSE_CYC
) (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       srst,
  // Link
  opvsr_link_if.host      lk,
  // User request
  input  wire logic       xfer_start,
  input  wire logic       ack_request_bit,
  input  wire logic [1:0] reg_select,
  input  wire logic [4:0] volt_data,
  input  wire logic       idle_high,
  // User status
  output logic            busy,
  output logic            done,
  output logic            ack_seen
);

  typedef struct packed {
    opvsr_pkg::opvsr_host_st_t   st;
    logic [2:0]                  sy;
    logic                        stab;
    logic [15:0]                 frame;
    logic [4:0]                  nbits;
    logic [opvsr_pkg::CNT_W-1:0] cnt;
    logic                        oe;
    logic                        busy;
    logic                        done;
    logic                        ack;
  } opvsr_host_state_t;

  localparam logic [opvsr_pkg::CNT_W-1:0] CNT_ONE   = 23'h000001;
  localparam logic [opvsr_pkg::CNT_W-1:0] ONE_LOW   =
    opvsr_pkg::CNT_W'(opvsr_pkg::HOST_BIT_CYC / 3);
  // Zero low is the bit less the one low, so both bits keep the 2x ratio
  localparam logic [opvsr_pkg::CNT_W-1:0] ZERO_LOW  = opvsr_pkg::HOST_BIT_CYC - ONE_LOW;
  localparam logic [opvsr_pkg::CNT_W-1:0] ACK_HOLD  =
    opvsr_pkg::ACK_VALID_CYC + opvsr_pkg::ACK_MARGIN_CYC;
  localparam logic [opvsr_pkg::CNT_W-1:0] ACK_LIMIT = ACK_PULSE_CYC + opvsr_pkg::ACK_MARGIN_CYC;

  opvsr_host_state_t st_ff;
  opvsr_host_state_t nxt_st;
  logic [opvsr_pkg::CNT_W-1:0] low_len;
  logic                        ack_req_ff;
  logic                        ack_pending;

  // Request bit kept apart, the frame register shifts it away
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ack_req_ff <= 1'b0;
    end else if (st_ff.st == opvsr_pkg::H_IDLE && xfer_start) begin
      ack_req_ff <= ack_request_bit;
    end
  end

  assign ack_pending = ack_req_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    nxt_st      = st_ff;
    nxt_st.sy   = {st_ff.sy[1:0], lk.line};
    nxt_st.stab = (st_ff.sy[1] == st_ff.sy[2]) ? st_ff.sy[2] : st_ff.stab;
    nxt_st.cnt  = st_ff.cnt + CNT_ONE;
    nxt_st.done = 1'b0;
    low_len     = st_ff.frame[15] ? ONE_LOW : ZERO_LOW; // RL19 RL12
    case (st_ff.st)
      opvsr_pkg::H_IDLE: begin
        nxt_st.oe = ~idle_high;
        if (xfer_start) begin
          nxt_st.frame = {opvsr_pkg::DEV_ADDR, ack_request_bit, reg_select, volt_data}; // RL8 RL9
          nxt_st.nbits = '0;
          nxt_st.ack   = 1'b0;
          nxt_st.busy  = 1'b1;
          nxt_st.st    = opvsr_pkg::H_START;
          nxt_st.cnt   = '0;
          nxt_st.oe    = 1'b0;
        end
      end
      opvsr_pkg::H_START: begin
        if (nxt_st.cnt == opvsr_pkg::HOST_START_CYC) begin
          nxt_st.st  = opvsr_pkg::H_LOW; // RL13
          nxt_st.cnt = '0;
          nxt_st.oe  = 1'b1;
        end
      end
      opvsr_pkg::H_LOW: begin
        if (nxt_st.cnt == low_len) begin
          nxt_st.st = opvsr_pkg::H_HIGH;
          nxt_st.oe = 1'b0;
        end
      end
      opvsr_pkg::H_HIGH: begin
        if (nxt_st.cnt == opvsr_pkg::HOST_BIT_CYC) begin
          nxt_st.frame = {st_ff.frame[14:0], 1'b0}; // RL12
          nxt_st.nbits = st_ff.nbits + 5'h01;
          nxt_st.cnt   = '0;
          nxt_st.oe    = 1'b1;
          nxt_st.st    = (nxt_st.nbits[2:0] == 3'h0) ? opvsr_pkg::H_EOS : opvsr_pkg::H_LOW;
        end
      end
      opvsr_pkg::H_EOS: begin
        // With a request the low is held past the device's valid delay
        if (st_ff.nbits == opvsr_pkg::FRAME_BITS && ack_pending) begin
          if (nxt_st.cnt == ACK_HOLD) begin
            nxt_st.st  = opvsr_pkg::H_ACKREL;
            nxt_st.cnt = '0;
            nxt_st.oe  = 1'b0;
          end
        end else if (nxt_st.cnt == opvsr_pkg::HOST_EOS_CYC) begin // RL14
          nxt_st.cnt = '0;
          if (st_ff.nbits == opvsr_pkg::FRAME_BITS) begin
            nxt_st.st   = opvsr_pkg::H_IDLE;
            nxt_st.busy = 1'b0;
            nxt_st.done = 1'b1;
            nxt_st.oe   = ~idle_high;
          end else begin
            nxt_st.st = opvsr_pkg::H_START; // RL13
            nxt_st.oe = 1'b0;
          end
        end
      end
      opvsr_pkg::H_ACKREL: begin
        if (nxt_st.cnt == opvsr_pkg::ACK_SAMPLE_CYC) begin
          nxt_st.ack = ~st_ff.stab; // RL21
          nxt_st.st  = opvsr_pkg::H_ACKWT;
          nxt_st.cnt = '0;
        end
      end
      opvsr_pkg::H_ACKWT: begin
        // The line is free again once the pulse ends
        if (st_ff.stab || nxt_st.cnt == ACK_LIMIT) begin
          nxt_st.st   = opvsr_pkg::H_IDLE;
          nxt_st.busy = 1'b0;
          nxt_st.done = 1'b1;
          nxt_st.oe   = ~idle_high;
        end
      end
      default: nxt_st.st = opvsr_pkg::H_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_ff      <= '0;
      st_ff.st   <= opvsr_pkg::H_IDLE;
      st_ff.sy   <= 3'h7;
      st_ff.stab <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign lk.host_o  = 1'b0;
  assign lk.host_oe = st_ff.oe;
  assign busy       = st_ff.busy;
  assign done       = st_ff.done;
  assign ack_seen   = st_ff.ack;

endmodule

// ### dv/opvsr_asserts.sv
// Checker for the shared wire between the host and device ends.
// Assumes open-drain ends with a pull-up; placed beside the link interface.
`timescale 1ns/1ps
module opvsr_asserts #(
  parameter logic [opvsr_pkg::CNT_W-1:0] ACK_PULSE_CYC = opvsr_pkg::ACK_PULSE_CYC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Link wire
  input wire logic line,
  input wire logic host_oe,
  input wire logic dev_oe
);
  ////////////////////////////////////////////////////////////////////////////
  // Counters kept here: the pulse is far too long for a repetition
  logic [15:0] ack_ff;
  logic [15:0] low_ff;
  always_ff @(posedge core_clk) begin
    ack_ff <= (srst || !dev_oe) ? 16'h0000 : ack_ff + 16'h0001;
    low_ff <= (srst || line) ? 16'h0000 : low_ff + 16'h0001;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  ////////////////////////////////////////////////////////////////////////////
  sequence s_ack_start; $rose(dev_oe); endsequence
  sequence s_host_pull; $rose(host_oe) ##0 host_oe[*8]; endsequence
  property p_drain; dev_oe |-> !line; endproperty
  property p_ack_len; $fell(dev_oe) |-> ack_ff == 16'(ACK_PULSE_CYC); endproperty
  property p_ack_max; dev_oe |-> ack_ff < 16'(ACK_PULSE_CYC); endproperty
  property p_ack_delay; s_ack_start |-> low_ff >= 16'(opvsr_pkg::ACK_VALID_CYC); endproperty
  property p_ack_host; s_ack_start |-> host_oe; endproperty
  property p_ack_gap; $fell(dev_oe) |-> (!dev_oe)[*8]; endproperty
  property p_host_low; $rose(host_oe) |-> s_host_pull; endproperty
  property p_host_high; $fell(host_oe) |-> (!host_oe)[*8]; endproperty
  property p_reset; disable iff (1'b0) srst |=> !dev_oe && !host_oe; endproperty
  a_drain: assert property (p_drain) else $error("line high while device pulls");
  a_ack_len: assert property (p_ack_len) else $error("ack pulse length wrong");
  a_ack_max: assert property (p_ack_max) else $error("ack pulse too long");
  a_ack_delay: assert property (p_ack_delay) else $error("ack too early");
  a_ack_host: assert property (p_ack_host) else $error("ack after host release");
  a_ack_gap: assert property (p_ack_gap) else $error("ack pulled again");
  a_host_low: assert property (p_host_low) else $error("host low too short");
  a_host_high: assert property (p_host_high) else $error("host high too short");
  a_reset: assert property (p_reset) else $error("wire pulled in lockout");
endmodule

// ### dv/test_one_pin_voltage_set_receiver.sv
// Bench joining host and device ends over one wire.
// Assumes shortened startup, power-save and ack counts set below.
`timescale 1ns/1ps
module test_one_pin_voltage_set_receiver;
  localparam logic [opvsr_pkg::CNT_W-1:0] ST = 23'h0000C8;
  localparam logic [opvsr_pkg::CNT_W-1:0] PS = 23'h0007D0;
  localparam logic [opvsr_pkg::CNT_W-1:0] AP = 23'h00012C;
  typedef struct packed {
    logic a; logic [1:0] s; logic [4:0] d; logic p; logic ea; logic [4:0] e1; logic [4:0] e2;
  } opvsr_row_t;
  // Rows run in order: each expects what earlier rows wrote
  opvsr_row_t rows [5] = '{
    '{1'b1, 2'h0, 5'h15, 1'b0, 1'b1, 5'h15, 5'h0C},
    '{1'b1, 2'h1, 5'h0A, 1'b0, 1'b1, 5'h15, 5'h0C},
    '{1'b0, 2'h2, 5'h1F, 1'b1, 1'b0, 5'h0A, 5'h1F},
    '{1'b1, 2'h3, 5'h03, 1'b1, 1'b0, 5'h0A, 5'h1F},
    '{1'b1, 2'h2, 5'h00, 1'b0, 1'b1, 5'h15, 5'h00}};
  logic       core_clk;
  logic       srst = 1'b1;
  logic       en1 = 1'b0;
  logic       en2 = 1'b0;
  logic       pin = 1'b0;
  logic       xs = 1'b0;
  logic       ar = 1'b0;
  logic [1:0] rs = 2'h0;
  logic [4:0] vd = 5'h00;
  logic       ih = 1'b1;
  logic [4:0] c1v, c2v;
  logic       pwm, r1, r2, ss1, ss2, sd, hs1, hs2, rdy, busy, done, ak;
  logic [1:0] ss_seen = 2'h0;
  logic       pwm_drop = 1'b0;
  int         err_count = 0;
  int         cmp_count = 0;
  ////////////////////////////////////////////////////////////////////////////
  opvsr_link_if i_opvsr_link_if ();
  opvsr_device #(.STARTUP_CYC(ST), .PSAVE_CYC(PS), .ACK_PULSE_CYC(AP)) i_opvsr_device (
    .core_clk, .srst, .lk(i_opvsr_link_if), .conv1_enable(en1), .conv2_enable(en2),
    .conv1_select_pin(pin), .conv1_voltage(c1v), .conv2_voltage(c2v), .pwm_forced(pwm),
    .conv1_run(r1), .conv2_run(r2), .conv1_soft_start(ss1), .conv2_soft_start(ss2),
    .shutdown(sd), .conv1_hs_on(hs1), .conv2_hs_on(hs2), .rx_ready(rdy));
  opvsr_host #(.ACK_PULSE_CYC(AP)) i_opvsr_host (
    .core_clk, .srst, .lk(i_opvsr_link_if), .xfer_start(xs), .ack_request_bit(ar),
    .reg_select(rs), .volt_data(vd), .idle_high(ih), .busy, .done, .ack_seen(ak));
  opvsr_asserts #(.ACK_PULSE_CYC(AP)) i_opvsr_asserts (
    .core_clk, .srst, .line(i_opvsr_link_if.line), .host_oe(i_opvsr_link_if.host_oe),
    .dev_oe(i_opvsr_link_if.dev_oe));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    ss_seen <= ss_seen | {ss2, ss1};
    pwm_drop <= pwm_drop | (busy === 1'b1 && pwm !== 1'b1);
  end
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic chk(input logic ok, input string m);
    cmp_count++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task automatic send(input opvsr_row_t r);
    int n;
    n = 0;
    ar = r.a;
    rs = r.s;
    vd = r.d;
    pin = r.p;
    xs = 1'b1;
    tick(1);
    xs = 1'b0;
    while (done !== 1'b1 && n < 9000) begin
      tick(1);
      n++;
    end
    chk(n < 9000, "no done");
  endtask
  task automatic end_sim;
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    tick(60000);
    err_count++;
    $display("[ERR] %0t watchdog expired", $time);
    end_sim;
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    tick(4);
    srst = 1'b0;
    tick(2);
    chk(sd === 1'b1 && pwm === 1'b1, "reset state");
    chk(c1v === opvsr_pkg::C1_LOW_DEF && c2v === opvsr_pkg::C2_DEF, "defaults");
    en1 = 1'b1;
    en2 = 1'b1;
    tick(8);
    chk(ss_seen === 2'h3 && r1 === 1'b1 && r2 === 1'b1 && sd === 1'b0, "start");
    chk(rdy === 1'b0, "ready early");
    tick(210);
    chk(rdy === 1'b1, "not ready");
    $display("enable test done");
    foreach (rows[i]) begin
      send(rows[i]);
      tick(4);
      chk(ak === rows[i].ea, "ack");
      chk(c1v === rows[i].e1 && c2v === rows[i].e2, "voltage");
      $display("row %0d done", i);
    end
    chk(pwm_drop === 1'b0, "pwm left in frame");
    while (hs1 !== 1'b1) tick(1);
    tick(5);
    chk(hs2 === 1'b1 && hs1 === 1'b0, "phase");
    ih = 1'b0;
    tick(1500);
    chk(pwm === 1'b1, "power save early");
    tick(600);
    chk(pwm === 1'b0, "power save late");
    ih = 1'b1;
    tick(6);
    chk(pwm === 1'b1, "pwm slow");
    $display("mode test done");
    en1 = 1'b0;
    en2 = 1'b0;
    tick(8);
    chk(sd === 1'b1 && r1 === 1'b0 && r2 === 1'b0, "shutdown");
    chk(c1v === 5'h15 && c2v === 5'h00, "retain");
    srst = 1'b1;
    tick(1);
    srst = 1'b0;
    tick(2);
    chk(c2v === opvsr_pkg::C2_DEF, "lockout");
    $display("lockout test done");
    end_sim;
  end
endmodule
